/* File: smcg_pkg.sv */
// Package: sleep mode clock gating constants, types and behaviour list
// Behaviour
// - Five software selectable power saving modes
// - Idle stops CPU, keeps SRAM, timers, SPI, interrupts
// - Power-down stops oscillator, wakes on interrupt/reset
// - Power-save keeps async timer and display running
// - Noise reduction keeps async timer, display, converter
// - Standby keeps crystal oscillator, rest sleeps
package smcg_pkg;
    // Mode codes of the software mode field
    localparam int SMCG_MODE_W = 3;
    localparam logic [2:0] SMCG_M_IDLE = 3'h0;
    localparam logic [2:0] SMCG_M_NOISE = 3'h1;
    localparam logic [2:0] SMCG_M_PDOWN = 3'h2;
    localparam logic [2:0] SMCG_M_PSAVE = 3'h3;
    localparam logic [2:0] SMCG_M_STBY = 3'h6;
    localparam logic [2:0] SMCG_MODE_RST = 3'h0;
    // Clock enable bundle, one bit per domain
    typedef struct packed {
        logic cpu;
        logic sram;
        logic timer;
        logic spi;
        logic irq;
        logic async_tmr;
        logic display;
        logic conv;
        logic osc;
    } smcg_clk_t;
    localparam smcg_clk_t SMCG_ALL_ON = 9'h1FF;
    // Wake sources
    typedef struct packed {
        logic ext_irq;
        logic async_irq;
        logic periph_irq;
        logic conv_done;
    } smcg_wake_t;
    typedef enum logic [1:0] {SMCG_RUN, SMCG_SLEEP, SMCG_WAKE} smcg_state_t;
endpackage : smcg_pkg

/* File: smcg_mode_decode.sv */
// Mode decoder: clock enables and wake permission per sleep mode
`timescale 1ns/10ps
module smcg_mode_decode
    import smcg_pkg::*;
(
    input wire logic [SMCG_MODE_W-1:0] i_mode,
    input wire logic i_sleeping,
    input wire smcg_wake_t i_wake,
    output smcg_clk_t o_clk_en,
    output logic o_wake_ok,
    output logic o_mode_valid
);
    // Clock map; unknown codes leave everything running for safety
    always_comb begin
        o_clk_en = SMCG_ALL_ON;
        o_mode_valid = 1'b1;
        o_wake_ok = 1'b0;
        if (i_sleeping) begin
            o_clk_en = '0;
            case (i_mode)
                SMCG_M_IDLE: begin
                    o_clk_en = SMCG_ALL_ON;
                    o_clk_en.cpu = 1'b0;
                    o_wake_ok = |i_wake;
                end
                SMCG_M_NOISE: begin
                    o_clk_en.async_tmr = 1'b1;
                    o_clk_en.display = 1'b1;
                    o_clk_en.conv = 1'b1;
                    o_clk_en.osc = 1'b1;
                    o_clk_en.irq = 1'b1;
                    o_wake_ok = |i_wake;
                end
                SMCG_M_PDOWN: begin
                    o_wake_ok = i_wake.ext_irq;
                end
                SMCG_M_PSAVE: begin
                    o_clk_en.async_tmr = 1'b1;
                    o_clk_en.display = 1'b1;
                    o_wake_ok = i_wake.ext_irq | i_wake.async_irq;
                end
                SMCG_M_STBY: begin
                    o_clk_en.osc = 1'b1;
                    o_wake_ok = i_wake.ext_irq;
                end
                default: begin
                    o_clk_en = SMCG_ALL_ON;
                    o_mode_valid = 1'b0;
                end
            endcase
        end
    end
endmodule : smcg_mode_decode

/* File: smcg_ctrl.sv */
// Top: sleep controller holding mode, request handling and wake
`timescale 1ns/10ps
module smcg_ctrl
    import smcg_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic i_mode_we,
    input wire logic [SMCG_MODE_W-1:0] i_mode_wdata,
    input wire logic i_sleep_req,
    input wire smcg_wake_t i_wake,
    output logic [SMCG_MODE_W-1:0] o_mode,
    output logic o_sleeping,
    output smcg_clk_t o_clk_en,
    output logic o_wake_pulse
);
    smcg_state_t state_q;
    logic [SMCG_MODE_W-1:0] mode_q;
    logic wake_q;
    logic wake_ok;
    logic mode_valid;
    smcg_clk_t clk_en;
    // Wake pin synchroniser, one bit per wake source
    localparam int WAKE_W = $bits(smcg_wake_t);
    logic [WAKE_W-1:0] wake_s1_q;
    logic [WAKE_W-1:0] wake_s2_q;
    logic [WAKE_W-1:0] wake_s3_q;
    logic [WAKE_W-1:0] wake_filt_q;
    logic [WAKE_W-1:0] wake_filt_d;
    smcg_wake_t wake_seen;

    smcg_mode_decode u_dec (
        .i_mode(mode_q),
        .i_sleeping(state_q == SMCG_SLEEP),
        .i_wake(wake_seen),
        .o_clk_en(clk_en),
        .o_wake_ok(wake_ok),
        .o_mode_valid(mode_valid)
    );

    // Wake sources come from pins and the async timer domain, so
    // they pass three stages before any decision is made on them
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wake_s1_q <= '0;
            wake_s2_q <= '0;
            wake_s3_q <= '0;
        end else if (i_ce) begin
            wake_s1_q <= i_wake;
            wake_s2_q <= wake_s1_q;
            wake_s3_q <= wake_s2_q;
        end
    end

    // A change counts once stages two and three agree; costs a
    // cycle of latency but a one-cycle glitch never wakes the chip
    for (genvar gi = 0; gi < WAKE_W; gi++) begin : g_wake_filt
        assign wake_filt_d[gi] = (wake_s2_q[gi] == wake_s3_q[gi]) ?
            wake_s2_q[gi] : wake_filt_q[gi];
    end

    // Filtered wake level, the only copy the decoder ever sees
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wake_filt_q <= '0;
        end else if (i_ce) begin
            wake_filt_q <= wake_filt_d;
        end
    end

    assign wake_seen = smcg_wake_t'(wake_filt_q);

    // Mode field; writes ignored while asleep since the CPU is stopped
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mode_q <= SMCG_MODE_RST;
        end else if (i_ce && i_mode_we && state_q == SMCG_RUN) begin
            mode_q <= i_mode_wdata;
        end
    end

    // Sleep sequencing; an invalid code leaves sleep on the next enabled cycle
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_q <= SMCG_RUN;
        end else if (i_ce) begin
            case (state_q)
                SMCG_RUN: begin
                    if (i_sleep_req && !i_mode_we) begin
                        state_q <= SMCG_SLEEP;
                    end
                end
                SMCG_SLEEP: begin
                    if (!mode_valid || wake_ok) begin
                        state_q <= SMCG_WAKE;
                    end
                end
                SMCG_WAKE: begin
                    state_q <= SMCG_RUN;
                end
                default: begin
                    state_q <= SMCG_RUN;
                end
            endcase
        end
    end

    // Registered clock enables and wake pulse
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_clk_en <= SMCG_ALL_ON;
            wake_q <= 1'b0;
        end else if (i_ce) begin
            o_clk_en <= clk_en;
            wake_q <= (state_q == SMCG_SLEEP) && wake_ok;
        end
    end

    assign o_mode = mode_q;
    assign o_sleeping = (state_q == SMCG_SLEEP);
    assign o_wake_pulse = wake_q;

    // Checks
    chk_idle_cpu_off: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_ce && state_q == SMCG_SLEEP && mode_q == SMCG_M_IDLE) |=>
        (!o_clk_en.cpu && o_clk_en.sram && o_clk_en.spi && o_clk_en.irq))
        else $error("idle clock map wrong");
    chk_pdown_osc_off: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_ce && state_q == SMCG_SLEEP && mode_q == SMCG_M_PDOWN) |=>
        (o_clk_en == '0))
        else $error("power-down left a clock on");
    chk_pdown_wake_src: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_ce && state_q == SMCG_SLEEP && mode_q == SMCG_M_PDOWN
         && !wake_seen.ext_irq) |=> (state_q == SMCG_SLEEP))
        else $error("power-down woke without interrupt");
    chk_psave_async_on: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_ce && state_q == SMCG_SLEEP && mode_q == SMCG_M_PSAVE) |=>
        (o_clk_en.async_tmr && o_clk_en.display && !o_clk_en.cpu))
        else $error("power-save clock map wrong");
    chk_noise_conv_on: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_ce && state_q == SMCG_SLEEP && mode_q == SMCG_M_NOISE) |=>
        (o_clk_en.conv && !o_clk_en.spi && !o_clk_en.cpu))
        else $error("noise reduction clock map wrong");
    chk_stby_osc_on: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_ce && state_q == SMCG_SLEEP && mode_q == SMCG_M_STBY) |=>
        (o_clk_en.osc && !o_clk_en.cpu && !o_clk_en.timer))
        else $error("standby clock map wrong");
    sequence s_wake_event;
        i_ce && state_q == SMCG_SLEEP && wake_ok;
    endsequence
    chk_wake_restore: assert property (@(posedge i_clk) disable iff (i_srst)
        s_wake_event ##1 i_ce ##1 1'b1 |-> (o_clk_en == SMCG_ALL_ON))
        else $error("clocks not restored after wake");
    chk_req_enters: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_ce && state_q == SMCG_RUN && i_sleep_req && !i_mode_we) |=>
        o_sleeping)
        else $error("sleep request not taken");
    chk_mode_hold: assert property (@(posedge i_clk) disable iff (i_srst)
        (state_q != SMCG_RUN) |=> $stable(mode_q))
        else $error("mode changed while asleep");

    // One sleeping cycle that the clock enable lets through
    sequence s_sleep_cycle;
        i_ce && state_q == SMCG_SLEEP;
    endsequence

    // Power-save only wakes on the pin or the async timer
    chk_psave_wake_src: assert property (@(posedge i_clk)
        disable iff (i_srst)
        (i_ce && state_q == SMCG_SLEEP && mode_q == SMCG_M_PSAVE
         && !wake_seen.ext_irq && !wake_seen.async_irq) |=>
        (state_q == SMCG_SLEEP))
        else $error("power-save woke on refused source");
    // Standby only wakes on the pin interrupt
    chk_stby_wake_src: assert property (@(posedge i_clk)
        disable iff (i_srst)
        (i_ce && state_q == SMCG_SLEEP && mode_q == SMCG_M_STBY
         && !wake_seen.ext_irq) |=> (state_q == SMCG_SLEEP))
        else $error("standby woke on refused source");
    // An unknown code falls straight out of sleep with clocks on
    chk_bad_code_exit: assert property (@(posedge i_clk)
        disable iff (i_srst)
        (s_sleep_cycle ##0 !mode_valid) |=>
        (!o_sleeping && o_clk_en == SMCG_ALL_ON))
        else $error("invalid code kept the chip asleep");
    // Map cannot drift while asleep, mode is locked then
    chk_map_steady: assert property (@(posedge i_clk)
        disable iff (i_srst)
        (s_sleep_cycle ##1 s_sleep_cycle) |=> $stable(o_clk_en))
        else $error("clock map drifted during sleep");
    // Every domain is clocked the cycle after an enabled cycle outside sleep
    chk_awake_all_on: assert property (@(posedge i_clk)
        disable iff (i_srst)
        (i_ce && state_q != SMCG_SLEEP) |=> (o_clk_en == SMCG_ALL_ON))
        else $error("clock gated while awake");
    // Wake pulse lasts exactly one enabled cycle
    chk_wake_pulse_one: assert property (@(posedge i_clk)
        disable iff (i_srst)
        (i_ce && o_wake_pulse) |=> !o_wake_pulse)
        else $error("wake pulse too long");
    // A write while running lands in the mode field
    chk_mode_write: assert property (@(posedge i_clk)
        disable iff (i_srst)
        (i_ce && i_mode_we && state_q == SMCG_RUN) |=>
        (o_mode == $past(i_mode_wdata)))
        else $error("mode write lost");
    // Clock enable low freezes every piece of state
    chk_ce_freeze: assert property (@(posedge i_clk)
        disable iff (i_srst)
        !i_ce |=> ($stable(state_q) && $stable(mode_q)
        && $stable(o_clk_en) && $stable(wake_filt_q)))
        else $error("state moved with clock enable low");
    // Filter never follows a source whose stages disagree
    chk_filter_hold: assert property (@(posedge i_clk)
        disable iff (i_srst)
        i_ce |=> (((wake_filt_q ^ $past(wake_filt_q))
        & ($past(wake_s2_q) ^ $past(wake_s3_q))) == '0))
        else $error("wake filter passed a glitch");
    // Agreeing stages are taken over on the next edge
    chk_filter_take: assert property (@(posedge i_clk)
        disable iff (i_srst)
        (i_ce && wake_s2_q == wake_s3_q) |=>
        (wake_filt_q == $past(wake_s2_q)))
        else $error("wake filter missed a settled source");
endmodule : smcg_ctrl

/* File: smcg_ctrl_test.sv */
// Testbench for the sleep mode clock gating controller
`timescale 1ns/10ps
module smcg_ctrl_test;
    import smcg_pkg::*;
    logic i_clk, i_srst, i_ce, i_mode_we, i_sleep_req;
    logic [SMCG_MODE_W-1:0] i_mode_wdata, o_mode;
    smcg_wake_t i_wake;
    smcg_clk_t o_clk_en;
    logic o_sleeping, o_wake_pulse;
    int n_fail = 0;
    int samples_checked = 0;
    smcg_ctrl u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce),
        .i_mode_we(i_mode_we), .i_mode_wdata(i_mode_wdata),
        .i_sleep_req(i_sleep_req), .i_wake(i_wake), .o_mode(o_mode),
        .o_sleeping(o_sleeping), .o_clk_en(o_clk_en),
        .o_wake_pulse(o_wake_pulse));
    // Free running 8 ns clock
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    // Compare and count; an unknown never matches
    task automatic chk(input string what, input logic [8:0] seen,
        input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Inputs move 1 ns after the edge, so no race with the design
    task automatic step();
        @(posedge i_clk);
        #1;
    endtask : step
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    // Write mode and request sleep on the following edge
    task automatic go_sleep(input logic [2:0] mode);
        i_mode_we = 1'b1;
        i_mode_wdata = mode;
        step();
        i_mode_we = 1'b0;
        i_sleep_req = 1'b1;
        chk("mode", 9'(o_mode), 9'(mode));
        step();
        i_sleep_req = 1'b0;
    endtask : go_sleep
    // Sleep in one mode, try a refused wake, then a permitted one
    task automatic sleep_case(input logic [2:0] mode, input smcg_clk_t map,
        input smcg_wake_t bad, input smcg_wake_t good);
        go_sleep(mode);
        i_mode_we = 1'b1; // Write while asleep must be dropped
        i_mode_wdata = ~mode;
        step();
        i_mode_we = 1'b0;
        chk("sleeping", 9'(o_sleeping), 9'h001);
        step();
        chk("clk_en", o_clk_en, map);
        i_wake = bad;
        repeat (6) step(); // Long enough to pass the pin filter
        chk("stay asleep", 9'(o_sleeping), 9'h001);
        chk("mode kept", 9'(o_mode), 9'(mode));
        i_wake = good;
        repeat (4) step();
        chk("wake latency", 9'(o_sleeping), 9'h001);
        step();
        chk("wake", {7'h00, o_sleeping, o_wake_pulse}, 9'h001);
        i_wake = '0;
        step();
        chk("clocks back", o_clk_en, SMCG_ALL_ON);
        chk("pulse ends", 9'(o_wake_pulse), 9'h000);
        repeat (4) step(); // Filtered wake must drop before next sleep
        $display("Sleep test for mode %h done", mode);
    endtask : sleep_case
    // Unknown code must leave every clock running
    task automatic bad_mode();
        go_sleep(3'h7);
        repeat (2) begin
            step();
            chk("bad code clocks", o_clk_en, SMCG_ALL_ON);
        end
        step();
        chk("bad code sleep", 9'(o_sleeping), 9'h000);
        $display("Invalid mode test done");
    endtask : bad_mode
    // Reset ends power-down; clock enable low freezes writes
    task automatic reset_case();
        go_sleep(SMCG_M_PDOWN);
        repeat (2) step();
        i_srst = 1'b1;
        step();
        i_srst = 1'b0;
        chk("reset sleep", 9'(o_sleeping), 9'h000);
        chk("reset clocks", o_clk_en, SMCG_ALL_ON);
        i_ce = 1'b0;
        i_mode_we = 1'b1;
        i_mode_wdata = SMCG_M_STBY;
        step();
        i_mode_we = 1'b0;
        i_ce = 1'b1;
        chk("frozen mode", 9'(o_mode), 9'(SMCG_MODE_RST));
        $display("Reset test done");
    endtask : reset_case
    // Bound well above the roughly 120 cycles the tests need
    initial begin
        #(8 * 2000);
        n_fail++;
        $display("Watchdog expired");
        final_report();
    end
    initial begin
        {i_srst, i_ce, i_mode_we, i_sleep_req} = 4'hC;
        i_mode_wdata = 3'h0;
        i_wake = '0;
        repeat (10) step();
        i_srst = 1'b0;
        chk("reset clk_en", o_clk_en, SMCG_ALL_ON);
        chk("reset mode", 9'(o_mode), 9'(SMCG_MODE_RST));
        sleep_case(SMCG_M_IDLE, 9'h0FF, 4'h0, 4'h2);
        sleep_case(SMCG_M_NOISE, 9'h01F, 4'h0, 4'h1);
        sleep_case(SMCG_M_PDOWN, 9'h000, 4'h4, 4'h8);
        sleep_case(SMCG_M_PSAVE, 9'h00C, 4'h2, 4'h4);
        sleep_case(SMCG_M_STBY, 9'h001, 4'h1, 4'h8);
        bad_mode();
        reset_case();
        final_report();
    end
endmodule : smcg_ctrl_test
